// ---- verilog/error_code_pkg.sv ----
// error code values, states and timing for the error code validator
// assumes a single 20 MHz clock domain
package error_code_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int CAL_TIMEOUT_S = 10;
    localparam int CAL_TIMEOUT_CYC = CAL_TIMEOUT_S * CLK_HZ;
    localparam int CNT_W = 28;

    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_BAD_VERSION = 16'h0050;
    localparam logic [15:0] CODE_BAD_CHECKSUM = 16'h0051;
    localparam logic [15:0] CODE_BAD_FACTORY = 16'h0053;
    localparam logic [15:0] CODE_RAM_FAIL = 16'h0061;
    localparam logic [15:0] CODE_FLASH_FAIL = 16'h0062;
    localparam logic [15:0] CODE_WATCHDOG = 16'h0063;
    localparam logic [15:0] CODE_WRONG_STATE = 16'h0064;
    localparam logic [15:0] CODE_OVER_RANGE = 16'h0065;
    localparam logic [15:0] CODE_UNDER_RANGE = 16'h0066;
    localparam logic [15:0] CODE_ODD_ADDR = 16'h0067;
    localparam logic [15:0] CODE_ODD_COUNT = 16'h0068;
    localparam logic [15:0] CODE_BAD_DECIMALS = 16'h0069;
    localparam logic [15:0] CODE_ENTER_DENIED = 16'h0082;
    localparam logic [15:0] CODE_EXIT_DENIED = 16'h0083;
    localparam logic [15:0] CODE_CAL_WEIGHT = 16'h00A0;
    localparam logic [15:0] CODE_CAL_TIMEOUT = 16'h00A2;
    localparam logic [15:0] CODE_READ_ONLY = 16'h00A3;
    localparam logic [15:0] CODE_BAD_REG = 16'h00A4;
    localparam logic [15:0] CODE_DIGITS_SAVE = 16'h00A5;
    localparam logic [15:0] CODE_BW_MISMATCH = 16'h00B3;
    localparam logic [15:0] CODE_DIGITS_EXIT = 16'h00BC;
    localparam logic [15:0] CODE_CAL2_HIGH = 16'h00BD;
    localparam logic [15:0] CODE_CAL2_SHEET = 16'h00BE;
    localparam logic [15:0] CODE_CAL_DIR = 16'h00BF;
    localparam logic [15:0] CODE_ANA_RANGE = 16'h00C0;
    localparam logic [15:0] PARAM_REG_LO = 16'hA028;
    localparam logic [15:0] PARAM_REG_HI = 16'hA3AC;

    localparam logic [3:0] MAX_DECIMALS = 4'h7;
    localparam logic [2:0] MAX_DIGITS = 3'h6;
    localparam logic [7:0] MAX_BW_RATIO = 8'h64;

    localparam logic [2:0] CMD_WRITE = 3'h0;
    localparam logic [2:0] CMD_ENTER_SETUP = 3'h1;
    localparam logic [2:0] CMD_ENTER_RESTORE = 3'h2;
    localparam logic [2:0] CMD_EXIT = 3'h3;
    localparam logic [2:0] CMD_RESET = 3'h4;
    localparam logic [2:0] CMD_CAL_START = 3'h5;
    localparam logic [2:0] CMD_OTHER = 3'h6;

    typedef enum logic [2:0] {
        ST_STARTUP = 3'b000,
        ST_OPERATE = 3'b001,
        ST_REMOTE_SETUP = 3'b010,
        ST_REMOTE_RESTORE = 3'b011,
        ST_CALIBRATE = 3'b100,
        ST_FATAL = 3'b101,
        ST_WATCHDOG = 3'b110
    } mode_e;
endpackage

// ---- verilog/error_code_validator.sv ----
// error detection and error code generation for a strain gauge transmitter
// assumes all inputs are synchronous to clk, pulse inputs last one cycle
`timescale 1ns/10ps
`default_nettype none
module error_code_validator #(
    parameter int CalTimeoutCycles = error_code_pkg::CAL_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic startupDone,
    input wire logic badVersion,
    input wire logic badChecksum,
    input wire logic [1:0] badFactory,
    input wire logic ramFail,
    input wire logic flashFail,
    input wire logic watchdogService,
    input wire logic [error_code_pkg::CNT_W-1:0] watchdogLimit,
    input wire logic cmdValid,
    input wire logic [2:0] cmdKind,
    input wire logic [15:0] wrStartReg,
    input wire logic [7:0] wrRegCount,
    input wire logic wrFloat,
    input wire logic wrScaled,
    input wire logic [3:0] wrDecimals,
    input wire logic wrOverRange,
    input wire logic wrUnderRange,
    input wire logic wrReadOnly,
    input wire logic wrUndefined,
    input wire logic [2:0] capacityDigits,
    input wire logic calWeightError,
    input wire logic calStable,
    input wire logic calDone,
    input wire logic [7:0] bwRatio,
    input wire logic cal2High,
    input wire logic cal2SheetBad,
    input wire logic calDirBad,
    input wire logic anaRangeBad,
    input wire logic paramOutOfRange,
    input wire logic [15:0] paramOutReg,
    input wire logic codeRead,
    input wire logic conditionClear,
    output logic [15:0] errorCode,
    output logic [2:0] mode,
    output logic loadDefaults,
    output logic inProcess,
    output logic relaysEnable,
    output logic analogZero,
    output logic cmdAccepted
);
    localparam int CNT_W_P = error_code_pkg::CNT_W;
    localparam logic [CNT_W_P-1:0] CAL_LIMIT = CNT_W_P'(CalTimeoutCycles - 1);

    typedef struct packed {
        error_code_pkg::mode_e mode;
        logic [15:0] code;
        logic [CNT_W_P-1:0] calCnt;
        logic [CNT_W_P-1:0] wdCnt;
        logic defaults;
        logic accepted;
        logic okOut;
        logic outZero;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;

    // consistency check order on exit; first hit wins
    function automatic logic [15:0] exit_check(input logic [2:0] digits, input logic [7:0] ratio,
                                               input logic c2h, input logic c2s,
                                               input logic dir, input logic ana,
                                               input logic oor, input logic [15:0] oreg);
        logic [15:0] r;
        r = error_code_pkg::CODE_NONE;
        if (ratio > error_code_pkg::MAX_BW_RATIO) begin
            r = error_code_pkg::CODE_BW_MISMATCH;
        end else if (digits > error_code_pkg::MAX_DIGITS) begin
            r = error_code_pkg::CODE_DIGITS_EXIT;
        end else if (c2s) begin
            r = error_code_pkg::CODE_CAL2_SHEET;
        end else if (c2h) begin
            r = error_code_pkg::CODE_CAL2_HIGH;
        end else if (dir) begin
            r = error_code_pkg::CODE_CAL_DIR;
        end else if (ana) begin
            r = error_code_pkg::CODE_ANA_RANGE;
        end else if (oor && oreg >= error_code_pkg::PARAM_REG_LO
                     && oreg <= error_code_pkg::PARAM_REG_HI) begin
            r = oreg;
        end
        return r;
    endfunction

    // write checks in fixed priority, structural faults before value faults
    function automatic logic [15:0] write_check(input logic [15:0] sreg, input logic [7:0] cnt,
                                                input logic flt, input logic scl,
                                                input logic [3:0] dec, input logic undef,
                                                input logic ro, input logic ovr,
                                                input logic und, input logic [2:0] digits);
        logic [15:0] r;
        r = error_code_pkg::CODE_NONE;
        if (undef) begin
            r = error_code_pkg::CODE_BAD_REG;
        end else if (sreg[0]) begin
            r = error_code_pkg::CODE_ODD_ADDR;
        end else if ((flt || scl) && cnt[0]) begin
            r = error_code_pkg::CODE_ODD_COUNT;
        end else if (scl && dec > error_code_pkg::MAX_DECIMALS) begin
            r = error_code_pkg::CODE_BAD_DECIMALS;
        end else if (ro) begin
            r = error_code_pkg::CODE_READ_ONLY;
        end else if (digits > error_code_pkg::MAX_DIGITS) begin
            r = error_code_pkg::CODE_DIGITS_SAVE;
        end else if (ovr) begin
            r = error_code_pkg::CODE_OVER_RANGE;
        end else if (und) begin
            r = error_code_pkg::CODE_UNDER_RANGE;
        end
        return r;
    endfunction

    logic [15:0] exitErr;
    logic [15:0] writeErr;
    logic remoteMode;
    logic [15:0] newErr;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.defaults = 1'b0;
        nxt_cur.accepted = 1'b0;
        newErr = error_code_pkg::CODE_NONE;
        exitErr = exit_check(capacityDigits, bwRatio, cal2High, cal2SheetBad, calDirBad,
                             anaRangeBad, paramOutOfRange, paramOutReg);
        writeErr = write_check(wrStartReg, wrRegCount, wrFloat, wrScaled, wrDecimals,
                               wrUndefined, wrReadOnly, wrOverRange, wrUnderRange,
                               capacityDigits);
        remoteMode = (cur_ff.mode == error_code_pkg::ST_REMOTE_SETUP)
                     || (cur_ff.mode == error_code_pkg::ST_REMOTE_RESTORE);

        // watchdog runs everywhere except while already tripped or fatal
        if (watchdogService) begin
            nxt_cur.wdCnt = '0;
        end else if (cur_ff.wdCnt != watchdogLimit) begin
            nxt_cur.wdCnt = cur_ff.wdCnt + 1'b1;
        end

        case (cur_ff.mode)
            error_code_pkg::ST_STARTUP: begin
                if (startupDone) begin
                    nxt_cur.wdCnt = '0;
                    if (ramFail) begin
                        newErr = error_code_pkg::CODE_RAM_FAIL;
                        nxt_cur.mode = error_code_pkg::ST_FATAL;
                    end else if (flashFail) begin
                        newErr = error_code_pkg::CODE_FLASH_FAIL;
                        nxt_cur.mode = error_code_pkg::ST_FATAL;
                    end else if (badFactory != 2'h0) begin
                        // low two bits select 053, 054 or 055
                        newErr = error_code_pkg::CODE_BAD_FACTORY
                                 + {14'h0000, badFactory} - 16'h0001;
                        nxt_cur.mode = error_code_pkg::ST_FATAL;
                    end else begin
                        nxt_cur.mode = error_code_pkg::ST_OPERATE;
                        if (badVersion) begin
                            newErr = error_code_pkg::CODE_BAD_VERSION;
                            nxt_cur.defaults = 1'b1;
                        end else if (badChecksum) begin
                            newErr = error_code_pkg::CODE_BAD_CHECKSUM;
                            nxt_cur.defaults = 1'b1;
                        end
                    end
                end
            end
            error_code_pkg::ST_FATAL: begin
                nxt_cur.wdCnt = '0;
            end
            error_code_pkg::ST_WATCHDOG: begin
                nxt_cur.wdCnt = '0;
                if (cmdValid && cmdKind == error_code_pkg::CMD_RESET) begin
                    nxt_cur.mode = error_code_pkg::ST_STARTUP;
                    nxt_cur.code = error_code_pkg::CODE_NONE;
                    nxt_cur.accepted = 1'b1;
                end else if (cmdValid) begin
                    newErr = error_code_pkg::CODE_WRONG_STATE;
                end
            end
            default: begin
                if (cur_ff.mode == error_code_pkg::ST_CALIBRATE) begin
                    nxt_cur.calCnt = cur_ff.calCnt + 1'b1;
                    if (calWeightError) begin
                        newErr = error_code_pkg::CODE_CAL_WEIGHT;
                        nxt_cur.mode = error_code_pkg::ST_REMOTE_SETUP;
                    end else if (calStable && calDone) begin
                        nxt_cur.mode = error_code_pkg::ST_REMOTE_SETUP;
                    end else if (!calStable && cur_ff.calCnt >= CAL_LIMIT) begin
                        newErr = error_code_pkg::CODE_CAL_TIMEOUT;
                        nxt_cur.mode = error_code_pkg::ST_REMOTE_SETUP;
                    end
                    if (calStable) begin
                        nxt_cur.calCnt = '0;
                    end
                end
                if (cmdValid) begin
                    case (cmdKind)
                        error_code_pkg::CMD_ENTER_SETUP, error_code_pkg::CMD_ENTER_RESTORE: begin
                            if (cur_ff.mode != error_code_pkg::ST_OPERATE) begin
                                newErr = error_code_pkg::CODE_ENTER_DENIED;
                            end else begin
                                nxt_cur.mode = (cmdKind == error_code_pkg::CMD_ENTER_SETUP)
                                    ? error_code_pkg::ST_REMOTE_SETUP
                                    : error_code_pkg::ST_REMOTE_RESTORE;
                                nxt_cur.accepted = 1'b1;
                            end
                        end
                        error_code_pkg::CMD_EXIT: begin
                            if (!remoteMode) begin
                                newErr = error_code_pkg::CODE_EXIT_DENIED;
                            end else if (exitErr != error_code_pkg::CODE_NONE) begin
                                newErr = exitErr;
                            end else begin
                                nxt_cur.mode = error_code_pkg::ST_OPERATE;
                                nxt_cur.accepted = 1'b1;
                            end
                        end
                        error_code_pkg::CMD_WRITE: begin
                            if (writeErr != error_code_pkg::CODE_NONE) begin
                                newErr = writeErr;
                            end else begin
                                nxt_cur.accepted = 1'b1;
                            end
                        end
                        error_code_pkg::CMD_CAL_START: begin
                            if (cur_ff.mode != error_code_pkg::ST_REMOTE_SETUP) begin
                                newErr = error_code_pkg::CODE_WRONG_STATE;
                            end else begin
                                nxt_cur.mode = error_code_pkg::ST_CALIBRATE;
                                nxt_cur.calCnt = '0;
                                nxt_cur.accepted = 1'b1;
                            end
                        end
                        error_code_pkg::CMD_RESET: begin
                            nxt_cur.mode = error_code_pkg::ST_STARTUP;
                            nxt_cur.code = error_code_pkg::CODE_NONE;
                            nxt_cur.accepted = 1'b1;
                        end
                        default: begin
                            newErr = error_code_pkg::CODE_WRONG_STATE;
                        end
                    endcase
                end
            end
        endcase

        // watchdog trip overrides the mode, code and command acceptance chosen this cycle
        if (cur_ff.mode != error_code_pkg::ST_FATAL && cur_ff.mode != error_code_pkg::ST_WATCHDOG
            && !watchdogService && cur_ff.wdCnt == watchdogLimit) begin
            newErr = error_code_pkg::CODE_WATCHDOG;
            nxt_cur.mode = error_code_pkg::ST_WATCHDOG;
            nxt_cur.accepted = 1'b0;
        end

        // a fresh error wins over a same-cycle read or clear
        if (newErr != error_code_pkg::CODE_NONE) begin
            nxt_cur.code = newErr;
        end else if ((codeRead || conditionClear)
                     && cur_ff.mode != error_code_pkg::ST_FATAL
                     && cur_ff.mode != error_code_pkg::ST_WATCHDOG) begin
            nxt_cur.code = error_code_pkg::CODE_NONE;
        end

        // taken from the next state so live outputs move with errorCode
        nxt_cur.okOut = (nxt_cur.code == error_code_pkg::CODE_NONE)
                        && (nxt_cur.mode == error_code_pkg::ST_OPERATE);
        nxt_cur.outZero = !nxt_cur.okOut;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cur_ff <= '{mode: error_code_pkg::ST_STARTUP, code: error_code_pkg::CODE_NONE,
                        calCnt: '0, wdCnt: '0, defaults: 1'b0, accepted: 1'b0,
                        okOut: 1'b0, outZero: 1'b1};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign errorCode = cur_ff.code;
    assign mode = cur_ff.mode;
    assign loadDefaults = cur_ff.defaults;
    assign cmdAccepted = cur_ff.accepted;
    assign inProcess = cur_ff.okOut;
    assign relaysEnable = cur_ff.okOut;
    assign analogZero = cur_ff.outZero;
endmodule
`default_nettype wire

// ---- testbench/control_unit_model.sv ----
// control unit model: issues one command per call and services the watchdog
// assumes it shares clk with the validator and is driven by the bench
`timescale 1ns/10ps
`default_nettype none
module control_unit_model (
    input wire logic clk,
    input wire logic serviceOn,
    output logic cmdValid,
    output logic [2:0] cmdKind,
    output logic [15:0] wrStartReg,
    output logic [7:0] wrRegCount,
    output logic wrFloat,
    output logic wrScaled,
    output logic [3:0] wrDecimals,
    output logic watchdogService
);
    logic [1:0] svcCnt = 2'h0;
    initial begin
        {cmdValid, cmdKind, wrStartReg, wrRegCount} = 28'h0;
        {wrFloat, wrScaled, wrDecimals, watchdogService} = 7'h0;
    end
    // service pulse every fourth cycle while enabled
    always @(posedge clk) begin
        svcCnt <= svcCnt + 2'h1;
        watchdogService <= serviceOn && (svcCnt == 2'h3);
    end
    // even start and count unless a scenario asks otherwise
    task automatic send(input logic [2:0] k, input logic [15:0] a, input logic [7:0] n,
                        input logic f, input logic s, input logic [3:0] d);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdKind <= k;
        wrStartReg <= a;
        wrRegCount <= n;
        {wrFloat, wrScaled, wrDecimals} <= {f, s, d};
        @(posedge clk);
        cmdValid <= 1'b0;
        // released start and count show the inverse so stale values never pass
        wrStartReg <= ~a;
        wrRegCount <= ~n;
    endtask
endmodule
`default_nettype wire

// ---- testbench/error_code_validator_properties.sv ----
// concurrent checks on the validator ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module error_code_validator_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic startupDone,
    input wire logic badVersion,
    input wire logic badChecksum,
    input wire logic [1:0] badFactory,
    input wire logic ramFail,
    input wire logic flashFail,
    input wire logic cmdValid,
    input wire logic [2:0] cmdKind,
    input wire logic [15:0] wrStartReg,
    input wire logic wrFloat,
    input wire logic wrUndefined,
    input wire logic [15:0] errorCode,
    input wire logic [2:0] mode,
    input wire logic loadDefaults,
    input wire logic inProcess,
    input wire logic relaysEnable,
    input wire logic analogZero,
    input wire logic cmdAccepted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_boot;
        mode == error_code_pkg::ST_STARTUP && startupDone && !flashFail && badFactory == 2'h0;
    endsequence
    sequence s_cmd(logic [2:0] k);
        cmdValid && cmdKind == k;
    endsequence
    property p_zero_ok;
        relaysEnable |-> errorCode == 16'h0000 && mode == error_code_pkg::ST_OPERATE;
    endproperty
    a_zero_ok: assert property (p_zero_ok) else $error("outputs live with error");
    property p_outputs;
        inProcess == relaysEnable && analogZero == !inProcess;
    endproperty
    a_outputs: assert property (p_outputs) else $error("output states disagree");
    property p_version;
        s_boot ##0 (badVersion && !badChecksum && !ramFail)
            |=> errorCode == 16'h0050 && loadDefaults;
    endproperty
    a_version: assert property (p_version) else $error("version fault not coded");
    property p_checksum;
        s_boot ##0 (badChecksum && !badVersion && !ramFail)
            |=> errorCode == 16'h0051 && loadDefaults;
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum fault not coded");
    property p_ram;
        s_boot ##0 ramFail |=> errorCode == 16'h0061 && mode == error_code_pkg::ST_FATAL;
    endproperty
    a_ram: assert property (p_ram) else $error("ram fault not fatal");
    property p_fatal_hold;
        mode == error_code_pkg::ST_FATAL |=> $stable(errorCode) && mode == $past(mode);
    endproperty
    a_fatal_hold: assert property (p_fatal_hold) else $error("fatal state left");
    property p_exit_denied;
        s_cmd(error_code_pkg::CMD_EXIT) ##0 mode == error_code_pkg::ST_OPERATE
            |=> errorCode == 16'h0083 && !cmdAccepted;
    endproperty
    a_exit_denied: assert property (p_exit_denied) else $error("exit not refused");
    property p_odd_addr;
        s_cmd(error_code_pkg::CMD_WRITE) ##0 (mode == error_code_pkg::ST_OPERATE && wrFloat
            && wrStartReg[0] && !wrUndefined) |=> errorCode == 16'h0067;
    endproperty
    a_odd_addr: assert property (p_odd_addr) else $error("odd start not coded");
    property p_wd_refuse;
        mode == error_code_pkg::ST_WATCHDOG && cmdValid && cmdKind != error_code_pkg::CMD_RESET
            |=> errorCode == 16'h0064 && mode == error_code_pkg::ST_WATCHDOG;
    endproperty
    a_wd_refuse: assert property (p_wd_refuse) else $error("watchdog left early");
    property p_reset_cmd;
        s_cmd(error_code_pkg::CMD_RESET) ##0 mode == error_code_pkg::ST_WATCHDOG
            |=> (mode == error_code_pkg::ST_STARTUP && errorCode == 16'h0000) [*2];
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
endmodule
bind error_code_validator error_code_validator_properties u_props (.clk, .reset,
    .startupDone, .badVersion, .badChecksum, .badFactory, .ramFail, .flashFail, .cmdValid,
    .cmdKind, .wrStartReg, .wrFloat, .wrUndefined, .errorCode, .mode, .loadDefaults,
    .inProcess, .relaysEnable, .analogZero, .cmdAccepted);
`default_nettype wire

// ---- testbench/error_code_validator_tb.sv ----
// self-checking bench for the error code validator
// assumes the control unit model drives the command, start, count and format inputs
`timescale 1ns/10ps
`default_nettype none
module error_code_validator_tb;
    logic clk = 1'b0, reset = 1'b1, sDone = 1'b0, rd = 1'b0, svcOn = 1'b1;
    logic [5:0] st = 6'h0;
    logic [12:0] lv = 13'h0;
    logic cmdValid, wrFloat, wrScaled, wdSvc, loadDefaults, inProcess, relaysEnable;
    logic analogZero, cmdAccepted;
    logic [2:0] cmdKind, mode;
    logic [15:0] wrStartReg, errorCode;
    logic [7:0] wrRegCount;
    logic [3:0] wrDecimals;
    int num_errors = 0, checks_done = 0, cyc = 0;
    initial forever #25 clk = ~clk;
    control_unit_model cu (.clk(clk), .serviceOn(svcOn), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .wrStartReg(wrStartReg), .wrRegCount(wrRegCount),
        .wrFloat(wrFloat), .wrScaled(wrScaled), .wrDecimals(wrDecimals),
        .watchdogService(wdSvc));
    error_code_validator #(.CalTimeoutCycles(50)) uut (.clk(clk), .reset(reset),
        .startupDone(sDone), .badVersion(st[0]), .badChecksum(st[1]), .badFactory(st[5:4]),
        .ramFail(st[2]), .flashFail(st[3]), .watchdogService(wdSvc),
        .watchdogLimit(28'h0000014), .cmdValid(cmdValid), .cmdKind(cmdKind),
        .wrStartReg(wrStartReg), .wrRegCount(wrRegCount), .wrFloat(wrFloat),
        .wrScaled(wrScaled), .wrDecimals(wrDecimals), .wrOverRange(lv[0]),
        .wrUnderRange(lv[1]), .wrReadOnly(lv[2]), .wrUndefined(lv[3]),
        .capacityDigits(lv[4] ? 3'h7 : 3'h6), .calWeightError(lv[12]), .calStable(!lv[11]),
        .calDone(1'b0), .bwRatio(lv[5] ? 8'h65 : 8'h64), .cal2High(lv[6]),
        .cal2SheetBad(lv[7]), .calDirBad(lv[8]), .anaRangeBad(lv[9]),
        .paramOutOfRange(lv[10]), .paramOutReg(16'hA05A), .codeRead(rd),
        .conditionClear(1'b0), .errorCode(errorCode), .mode(mode),
        .loadDefaults(loadDefaults), .inProcess(inProcess), .relaysEnable(relaysEnable),
        .analogZero(analogZero), .cmdAccepted(cmdAccepted));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic boot(input logic [5:0] s);
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        st <= s;
        sDone <= 1'b1;
        @(posedge clk);
        sDone <= 1'b0;
        st <= 6'h0;
        #1;
    endtask
    task automatic go(input logic [2:0] k, input logic [12:0] l);
        @(posedge clk);
        lv <= l;
        cu.send(k, 16'hA028, 8'h02, 1'b0, 1'b0, 4'h0);
        tick(1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] n, input logic f, input logic s,
                      input logic [3:0] d, input logic [12:0] l, input logic [15:0] e);
        @(posedge clk);
        lv <= l;
        cu.send(3'h0, a, n, f, s, d);
        #1;
        chk("write code", e, errorCode);
        chk("accepted", {15'h0, e == 16'h0}, {15'h0, cmdAccepted});
        @(posedge clk);
        lv <= 13'h0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        tick(1);
        chk("code after read", 16'h0000, errorCode);
    endtask
    task automatic t_startup;
        logic [5:0] s [7] = '{6'h01, 6'h02, 6'h10, 6'h20, 6'h30, 6'h04, 6'h08};
        logic [15:0] c [7] = '{16'h50, 16'h51, 16'h53, 16'h54, 16'h55, 16'h61, 16'h62};
        for (int i = 0; i < 7; i++) begin
            boot(s[i]);
            chk("startup code", c[i], errorCode);
            chk("defaults", {15'h0, i < 2}, {15'h0, loadDefaults});
            go(error_code_pkg::CMD_EXIT, 13'h0);
            if (i >= 2) chk("fatal held", c[i], errorCode);
        end
        boot(6'h00);
        chk("clean code", 16'h0000, errorCode);
        chk("in process", 16'h0001, {15'h0, inProcess});
    endtask
    task automatic t_write;
        wr(16'hA029, 8'h02, 1'b1, 1'b0, 4'h0, 13'h000, 16'h0067);
        wr(16'hA028, 8'h03, 1'b1, 1'b0, 4'h0, 13'h000, 16'h0068);
        wr(16'hA028, 8'h02, 1'b0, 1'b1, 4'h8, 13'h000, 16'h0069);
        wr(16'hA028, 8'h02, 1'b0, 1'b1, 4'h7, 13'h000, 16'h0000);
        wr(16'hA028, 8'h02, 1'b1, 1'b0, 4'h0, 13'h001, 16'h0065);
        wr(16'hA028, 8'h02, 1'b1, 1'b0, 4'h0, 13'h002, 16'h0066);
        wr(16'hA028, 8'h02, 1'b1, 1'b0, 4'h0, 13'h004, 16'h00A3);
        wr(16'hA029, 8'h03, 1'b1, 1'b0, 4'h0, 13'h008, 16'h00A4);
        wr(16'hA028, 8'h02, 1'b1, 1'b0, 4'h0, 13'h010, 16'h00A5);
    endtask
    task automatic t_setup;
        logic [15:0] e [7] = '{16'hB3, 16'hBD, 16'hBE, 16'hBF, 16'hC0, 16'hA05A, 16'hBC};
        int b [7] = '{5, 6, 7, 8, 9, 10, 4};
        go(error_code_pkg::CMD_EXIT, 13'h0);
        chk("exit denied", 16'h0083, errorCode);
        go(error_code_pkg::CMD_ENTER_SETUP, 13'h0);
        chk("setup mode", 16'(error_code_pkg::ST_REMOTE_SETUP), {13'h0, mode});
        go(error_code_pkg::CMD_ENTER_RESTORE, 13'h0);
        chk("enter denied", 16'h0082, errorCode);
        for (int i = 0; i < 7; i++) begin
            go(error_code_pkg::CMD_EXIT, 13'h1 << b[i]);
            chk("exit fault", e[i], errorCode);
            chk("exit held", 16'(error_code_pkg::ST_REMOTE_SETUP), {13'h0, mode});
        end
        go(error_code_pkg::CMD_EXIT, 13'h0);
        chk("exit ok", 16'(error_code_pkg::ST_OPERATE), {13'h0, mode});
    endtask
    task automatic t_cal_wd;
        int n;
        go(error_code_pkg::CMD_ENTER_SETUP, 13'h0);
        go(error_code_pkg::CMD_CAL_START, 13'h0800);
        for (n = 0; errorCode !== 16'h00A2 && n < 200; n++) tick(1);
        chk("cal timeout", 16'h0001, {15'h0, n >= 40 && n <= 55});
        boot(6'h00);
        go(error_code_pkg::CMD_ENTER_SETUP, 13'h0);
        go(error_code_pkg::CMD_CAL_START, 13'h1000);
        tick(2);
        chk("cal weight", 16'h00A0, errorCode);
        boot(6'h00);
        @(posedge clk);
        svcOn <= 1'b0;
        for (n = 0; errorCode !== 16'h0063 && n < 200; n++) tick(1);
        chk("watchdog code", 16'h0063, errorCode);
        go(error_code_pkg::CMD_ENTER_SETUP, 13'h0);
        chk("wrong state", 16'h0064, errorCode);
        @(posedge clk);
        svcOn <= 1'b1;
        go(error_code_pkg::CMD_RESET, 13'h0);
        chk("reset cmd", 16'(error_code_pkg::ST_STARTUP), {13'h0, mode});
        chk("reset code", 16'h0000, errorCode);
    endtask
    initial begin
        t_startup();
        t_write();
        t_setup();
        t_cal_wd();
        tally_and_finish();
    end
endmodule
`default_nettype wire
